// file: common/fcw_pkg.sv
/*
 * Constants, command codes, states and carriers of the flash command front end.
 * Assumes a 25 MHz core clock and a host that writes 16-bit command cycles.
 */
package fcw_pkg;

	// ****************************************
	// Bus widths and address map
	// ****************************************
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;
	localparam logic [21:0] BANK_A_BASE = 22'h300000;
	localparam logic [11:0] UNLK_ADDR1 = 12'h555;
	localparam logic [11:0] UNLK_ADDR2 = 12'h2AA;
	localparam int WS_LSB = 12;

	// ****************************************
	// Command codes (low byte of the data word)
	// ****************************************
	localparam logic [7:0] CMD_UNLK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLK2 = 8'h55;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_ASEL = 8'h90;
	localparam logic [7:0] CMD_PGM = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERS = 8'h10;
	localparam logic [7:0] CMD_SECT_ERS = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_WAIT = 8'hC0;

	// ****************************************
	// Wait-state setting
	// ****************************************
	localparam logic [2:0] WAIT_BASE = 3'h4;
	localparam logic [2:0] WAIT_DEFAULT = 3'h7;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		FCW_READ = 4'h0,
		FCW_UNLK1 = 4'h1,
		FCW_UNLK2 = 4'h3,
		FCW_PGM_SET = 4'h2,
		FCW_PGM_BUSY = 4'h6,
		FCW_ERS_SET = 4'h7,
		FCW_ERS_U1 = 4'h5,
		FCW_ERS_U2 = 4'h4,
		FCW_ERS_BUSY = 4'hC,
		FCW_ASEL = 4'hD
	} fcw_state_t;

	typedef enum logic [1:0] {
		FCW_MODE_READ = 2'h0,
		FCW_MODE_ESR = 2'h1,
		FCW_MODE_BUSY = 2'h2,
		FCW_MODE_ASEL = 2'h3
	} fcw_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} fcw_wr_t;

	typedef struct packed {
		fcw_mode_t mode;
		logic op_start;
		logic op_erase;
		logic ws_cmd;
	} fcw_bank_t;

endpackage : fcw_pkg

// file: rtl/fcw_bank_seq.sv
/*
 * Per-bank command sequencer: unlock cycles, program, erase, suspend,
 * autoselect and wait-state command recognition.
 * Assumes one-cycle write pulses already routed to this bank and an
 * op_done pulse from the embedded algorithm on the same clock.
 */
module fcw_bank_seq
	import fcw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_valid,
	input fcw_pkg::fcw_wr_t wr,
	input wire logic op_done,
	output fcw_pkg::fcw_bank_t stat
);

	// ****************************************
	// State
	// ****************************************
	fcw_state_t state_q, state_d;
	logic esusp_q, esusp_d;
	fcw_bank_t stat_q, stat_d;
	logic [11:0] lo;
	logic [7:0] cmd;

	assign lo = wr.addr[11:0];
	assign cmd = wr.data[7:0];
	assign stat = stat_q;

	// Next state; status is derived from the next state so it lines up with state_q
	always_comb begin
		state_d = state_q;
		esusp_d = esusp_q;
		stat_d = '0;
		stat_d.op_erase = stat_q.op_erase;
		case (state_q)
			FCW_PGM_BUSY: begin
				// Every write, reset included, is dropped until done
				if (op_done) state_d = FCW_READ;
			end
			FCW_ERS_BUSY: begin
				// Only suspend is heard while erasing; reset is ignored
				if (op_done) begin
					state_d = FCW_READ;
				end else if (wr_valid && cmd == CMD_SUSPEND) begin
					state_d = FCW_READ;
					esusp_d = 1'b1;
				end
			end
			default: begin
				if (!wr_valid) begin
					state_d = state_q;
				end else if (cmd == CMD_RESET) begin
					state_d = FCW_READ;
				end else begin
					case (state_q)
						FCW_READ: begin
							if (cmd == CMD_UNLK1 && lo == UNLK_ADDR1) begin
								state_d = FCW_UNLK1;
							end else if (esusp_q && cmd == CMD_RESUME) begin
								state_d = FCW_ERS_BUSY;
								esusp_d = 1'b0;
							end
						end
						FCW_UNLK1: begin
							if (cmd == CMD_UNLK2 && lo == UNLK_ADDR2) state_d = FCW_UNLK2;
							else state_d = FCW_READ;
						end
						FCW_UNLK2: begin
							state_d = FCW_READ;
							if (lo == UNLK_ADDR1) begin
								if (cmd == CMD_ASEL) state_d = FCW_ASEL;
								else if (cmd == CMD_PGM) state_d = FCW_PGM_SET;
								else if (cmd == CMD_ERASE && !esusp_q) state_d = FCW_ERS_SET;
								else if (cmd == CMD_WAIT) stat_d.ws_cmd = 1'b1;
							end
						end
						FCW_PGM_SET: begin
							state_d = FCW_PGM_BUSY;
							stat_d.op_start = 1'b1;
							stat_d.op_erase = 1'b0;
						end
						FCW_ERS_SET: begin
							if (cmd == CMD_UNLK1 && lo == UNLK_ADDR1) state_d = FCW_ERS_U1;
							else state_d = FCW_READ;
						end
						FCW_ERS_U1: begin
							if (cmd == CMD_UNLK2 && lo == UNLK_ADDR2) state_d = FCW_ERS_U2;
							else state_d = FCW_READ;
						end
						FCW_ERS_U2: begin
							if ((cmd == CMD_CHIP_ERS && lo == UNLK_ADDR1) || cmd == CMD_SECT_ERS) begin
								state_d = FCW_ERS_BUSY;
								stat_d.op_start = 1'b1;
								stat_d.op_erase = 1'b1;
							end else begin
								state_d = FCW_READ;
							end
						end
						FCW_ASEL: state_d = FCW_ASEL;
						default: state_d = FCW_READ;
					endcase
				end
			end
		endcase
		if (state_d == FCW_PGM_BUSY || state_d == FCW_ERS_BUSY) stat_d.mode = FCW_MODE_BUSY;
		else if (state_d == FCW_ASEL) stat_d.mode = FCW_MODE_ASEL;
		else if (esusp_d) stat_d.mode = FCW_MODE_ESR;
		else stat_d.mode = FCW_MODE_READ;
	end

	// Registers; reset lands in array read
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= FCW_READ;
			esusp_q <= 1'b0;
			stat_q <= '0;
		end else begin
			state_q <= state_d;
			esusp_q <= esusp_d;
			stat_q <= stat_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_pwr_read: assert property ($past(rst) |-> stat.mode == FCW_MODE_READ)
		else $error("bank not in read after reset");
	a_done_read: assert property (state_q == FCW_PGM_BUSY && op_done
		|=> stat.mode == (esusp_q ? FCW_MODE_ESR : FCW_MODE_READ))
		else $error("bank did not leave busy on done");
	a_suspend_esr: assert property (state_q == FCW_ERS_BUSY && !op_done && wr_valid
		&& cmd == CMD_SUSPEND |=> stat.mode == FCW_MODE_ESR)
		else $error("suspend did not enter suspend-read");
	a_busy_ignore: assert property ((state_q == FCW_PGM_BUSY || state_q == FCW_ERS_BUSY)
		&& !op_done && wr_valid && cmd == CMD_RESET |=> stat.mode == FCW_MODE_BUSY)
		else $error("reset command honoured while busy");
	a_asel_hold: assert property (state_q == FCW_ASEL && wr_valid && cmd != CMD_RESET
		|=> stat.mode == FCW_MODE_ASEL [*2])
		else $error("autoselect left without reset");
	a_bad_unlock: assert property (state_q == FCW_UNLK1 && wr_valid
		&& !(cmd == CMD_UNLK2 && lo == UNLK_ADDR2) |=> state_q == FCW_READ)
		else $error("bad second cycle did not abort");
	a_reset_cmd: assert property (state_q != FCW_PGM_BUSY && state_q != FCW_ERS_BUSY
		&& wr_valid && cmd == CMD_RESET
		|=> stat.mode == ($past(esusp_q) ? FCW_MODE_ESR : FCW_MODE_READ))
		else $error("reset command gave wrong mode");

endmodule : fcw_bank_seq

// file: rtl/fcw_cmd_decode.sv
/*
 * Command front end of a dual-bank burst flash: pin synchronisers,
 * address and data capture, bank routing, wait-state setting and the
 * burst initial-access counter.
 * Assumes all pins, the burst clock included, are asynchronous to clk
 * and that the host holds each strobe level for well over three clk periods.
 */
module fcw_cmd_decode
	import fcw_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic address_valid_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [fcw_pkg::ADDR_W-1:0] addr_pins,
	input wire logic [fcw_pkg::DATA_W-1:0] data_pins,
	input wire logic burst_clk,
	input wire logic op_done_a,
	input wire logic op_done_b,
	output fcw_pkg::fcw_bank_t bank_a_stat,
	output fcw_pkg::fcw_bank_t bank_b_stat,
	output logic [2:0] wait_cycles,
	output logic first_access_ready
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic avd_s1_q, avd_s2_q, avd_s3_q;
	logic we_s1_q, we_s2_q, we_s3_q;
	logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
	logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
	logic [DATA_W-1:0] data_s1_q, data_s2_q;
	logic avd_rise, we_rise, bclk_rise;

	// Two stages per pin; the third stage on the strobes and the burst clock exists only for edge detection
	always_ff @(posedge clk) begin
		if (rst) begin
			avd_s1_q <= 1'b1;
			avd_s2_q <= 1'b1;
			avd_s3_q <= 1'b1;
			we_s1_q <= 1'b1;
			we_s2_q <= 1'b1;
			we_s3_q <= 1'b1;
			bclk_s1_q <= 1'b0;
			bclk_s2_q <= 1'b0;
			bclk_s3_q <= 1'b0;
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			data_s1_q <= '0;
			data_s2_q <= '0;
		end else begin
			avd_s1_q <= address_valid_strobe_n;
			avd_s2_q <= avd_s1_q;
			avd_s3_q <= avd_s2_q;
			we_s1_q <= write_strobe_n;
			we_s2_q <= we_s1_q;
			we_s3_q <= we_s2_q;
			bclk_s1_q <= burst_clk;
			bclk_s2_q <= bclk_s1_q;
			bclk_s3_q <= bclk_s2_q;
			addr_s1_q <= addr_pins;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= data_pins;
			data_s2_q <= data_s1_q;
		end
	end

	// Rising edges seen on the synchronised levels
	assign avd_rise = avd_s2_q && !avd_s3_q;
	assign we_rise = we_s2_q && !we_s3_q;
	assign bclk_rise = bclk_s2_q && !bclk_s3_q;

	// ****************************************
	// Command cycle capture
	// ****************************************
	logic [ADDR_W-1:0] addr_q, addr_d;
	fcw_wr_t wr_q, wr_d;
	logic wr_vld_q, wr_vld_d;

	// Address waits in addr_q until the write strobe closes the cycle
	always_comb begin
		addr_d = addr_q;
		wr_d = wr_q;
		wr_vld_d = 1'b0;
		if (avd_rise) addr_d = addr_s2_q;
		if (we_rise) begin
			wr_d.addr = addr_q;
			wr_d.data = data_s2_q;
			wr_vld_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			addr_q <= '0;
			wr_q <= '0;
			wr_vld_q <= 1'b0;
		end else begin
			addr_q <= addr_d;
			wr_q <= wr_d;
			wr_vld_q <= wr_vld_d;
		end
	end

	// ****************************************
	// Bank routing and sequencers
	// ****************************************
	logic sel_a, vld_a, vld_b;
	fcw_bank_t stat_a, stat_b;

	// Boot bank sits at the top of the word space
	assign sel_a = (wr_q.addr >= BANK_A_BASE);
	assign vld_a = wr_vld_q && sel_a;
	assign vld_b = wr_vld_q && !sel_a;

	// One sequencer per bank keeps each bank's progress apart
	fcw_bank_seq u_bank_a (
		.clk(clk),
		.rst(rst),
		.wr_valid(vld_a),
		.wr(wr_q),
		.op_done(op_done_a),
		.stat(stat_a)
	);

	fcw_bank_seq u_bank_b (
		.clk(clk),
		.rst(rst),
		.wr_valid(vld_b),
		.wr(wr_q),
		.op_done(op_done_b),
		.stat(stat_b)
	);

	assign bank_a_stat = stat_a;
	assign bank_b_stat = stat_b;

	// ****************************************
	// Wait-state setting
	// ****************************************
	logic [2:0] wait_q, wait_d;
	logic ws_hit;

	// wr_q is held until the next write, so the third-cycle address is still valid
	assign ws_hit = stat_a.ws_cmd || stat_b.ws_cmd;

	always_comb begin
		wait_d = wait_q;
		if (ws_hit) begin
			wait_d = WAIT_BASE + {1'b0, wr_q.addr[WS_LSB+1:WS_LSB]};
		end
	end

	// Reset restores the slowest setting, safe at any clock rate
	always_ff @(posedge clk) begin
		if (rst) wait_q <= WAIT_DEFAULT;
		else wait_q <= wait_d;
	end

	assign wait_cycles = wait_q;

	// ****************************************
	// Burst initial-access counter
	// ****************************************
	logic [2:0] cnt_q, cnt_d;
	logic run_q, run_d;
	logic rdy_q, rdy_d;

	// Every address strobe opens an access; ready rises after wait_q burst clocks.
	// Reads and writes are not told apart here: a write simply ends unused.
	always_comb begin
		cnt_d = cnt_q;
		run_d = run_q;
		rdy_d = rdy_q;
		if (avd_rise) begin
			cnt_d = '0;
			run_d = 1'b1;
			rdy_d = 1'b0;
		end else if (run_q && bclk_rise) begin
			if (cnt_q + 3'h1 == wait_q) begin
				run_d = 1'b0;
				rdy_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 3'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
			run_q <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			run_q <= run_d;
			rdy_q <= rdy_d;
		end
	end

	assign first_access_ready = rdy_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_addr_capture: assert property (avd_rise |=> addr_q == $past(addr_s2_q))
		else $error("address not captured on strobe edge");
	a_data_capture: assert property (we_rise
		|=> wr_vld_q && wr_q.data == $past(data_s2_q) && wr_q.addr == $past(addr_q))
		else $error("data not captured on write edge");
	a_ws_decode: assert property (ws_hit
		|=> wait_q == WAIT_BASE + {1'b0, $past(wr_q.addr[WS_LSB+1:WS_LSB])})
		else $error("wait setting decoded wrongly");
	a_ws_default: assert property ($past(rst) |-> wait_q == WAIT_DEFAULT)
		else $error("wait setting not default after reset");
	a_ready_count: assert property ($rose(rdy_q)
		|-> $past(cnt_q) + 3'h1 == $past(wait_q) && $past(bclk_rise))
		else $error("initial access ended at wrong count");
	a_ready_clear: assert property (avd_rise |=> !rdy_q && run_q && cnt_q == 3'h0)
		else $error("access counter not restarted");
	a_bank_route: assert property (wr_vld_q && wr_q.data[7:0] == CMD_RESET
		&& wr_q.addr < BANK_A_BASE && bank_a_stat.mode == FCW_MODE_ASEL
		|=> bank_a_stat.mode == FCW_MODE_ASEL)
		else $error("bank B write disturbed bank A");

endmodule : fcw_cmd_decode

// file: dv/fcw_host_model.sv
/*
 * Host controller model: command write cycles, address strobes, burst clock.
 * Assumes the decoder's 25 MHz clk; every strobe level lasts 3 clk or more.
 */
module fcw_host_model
	import fcw_pkg::*;
(
	input wire logic clk,
	output logic address_valid_strobe_n,
	output logic write_strobe_n,
	output logic [fcw_pkg::ADDR_W-1:0] addr_pins,
	output logic [fcw_pkg::DATA_W-1:0] data_pins,
	output logic burst_clk
);
	timeunit 1ns;
	timeprecision 1ns;

	// ****************************************
	// Bus cycles
	// ****************************************
	// Idle pins; burst clock stands still outside frames
	initial begin
		address_valid_strobe_n = 1'b1;
		write_strobe_n = 1'b1;
		addr_pins = '0;
		data_pins = '0;
		burst_clk = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Released bus shows the inverse, so a decoder reading late sees junk
	task automatic strobe(input logic [ADDR_W-1:0] a);
		@(posedge clk);
		address_valid_strobe_n <= 1'b0;
		addr_pins <= a;
		tick(4);
		address_valid_strobe_n <= 1'b1;
		tick(3);
		addr_pins <= ~a;
	endtask : strobe

	// Wrong data early in the low phase, right data around the rising edge
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		strobe(a);
		write_strobe_n <= 1'b0;
		data_pins <= ~d;
		tick(2);
		data_pins <= d;
		tick(2);
		write_strobe_n <= 1'b1;
		tick(3);
		data_pins <= ~d;
		tick(1);
	endtask : wr

	// Two unlock cycles in the target bank, then the command cycle
	task automatic cmd3(input logic [ADDR_W-1:0] a, input logic [7:0] c);
		wr({a[21:12], UNLK_ADDR1}, {8'h00, CMD_UNLK1});
		wr({a[21:12], UNLK_ADDR2}, {8'h00, CMD_UNLK2});
		wr(a, {8'h00, c});
	endtask : cmd3

	// Address bits are junk on purpose
	task automatic reset_cmd(input logic [ADDR_W-1:0] a);
		wr(a | 22'h000ABC, {8'h00, CMD_RESET});
	endtask : reset_cmd

	// Burst clock at 320 ns period, n rises, then still
	task automatic rises(input int n);
		@(posedge clk);
		repeat (n) begin
			burst_clk <= 1'b1;
			tick(4);
			burst_clk <= 1'b0;
			tick(4);
		end
	endtask : rises
endmodule : fcw_host_model

// file: dv/flash_command_waitstate_decode_tb.sv
/*
 * Self-checking bench of the flash command front end.
 * Assumes fcw_host_model drives every pin; op_done pulses come from here.
 */
module flash_command_waitstate_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import fcw_pkg::*;

	typedef struct {
		logic [ADDR_W-1:0] a;
		logic [7:0] d;
		fcw_mode_t ma;
		fcw_mode_t mb;
		logic [2:0] w;
	} fcw_row_t;

	logic clk;
	logic rst;
	logic address_valid_strobe_n, write_strobe_n, burst_clk;
	logic [ADDR_W-1:0] addr_pins;
	logic [DATA_W-1:0] data_pins;
	logic op_done_a;
	logic op_done_b;
	logic [7:0] start_count = 8'h00;
	logic [7:0] ws_count = 8'h00;
	fcw_bank_t bank_a_stat, bank_b_stat;
	logic [2:0] wait_cycles;
	logic first_access_ready;
	int fail_count = 0;
	int checks = 0;
	fcw_row_t rows [8];

	// ****************************************
	// Clock, partner and design
	// ****************************************
	// Starts from unknown; first rise at 20 ns, then plain inversion
	always #20 clk = (clk !== 1'b1);

	// Pulse counters; stat is read before the edge replaces it
	always @(posedge clk) begin
		if (bank_a_stat.op_start || bank_b_stat.op_start) start_count <= start_count + 8'h01;
		if (bank_a_stat.ws_cmd || bank_b_stat.ws_cmd) ws_count <= ws_count + 8'h01;
	end

	fcw_host_model fcw_host_model_i (
		.clk(clk),
		.address_valid_strobe_n(address_valid_strobe_n),
		.write_strobe_n(write_strobe_n),
		.addr_pins(addr_pins),
		.data_pins(data_pins),
		.burst_clk(burst_clk)
	);

	fcw_cmd_decode fcw_cmd_decode_i (
		.clk(clk),
		.rst(rst),
		.address_valid_strobe_n(address_valid_strobe_n),
		.write_strobe_n(write_strobe_n),
		.addr_pins(addr_pins),
		.data_pins(data_pins),
		.burst_clk(burst_clk),
		.op_done_a(op_done_a),
		.op_done_b(op_done_b),
		.bank_a_stat(bank_a_stat),
		.bank_b_stat(bank_b_stat),
		.wait_cycles(wait_cycles),
		.first_access_ready(first_access_ready)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk

	// Sample at the falling edge, well clear of register updates
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : settle

	task automatic modes(input fcw_mode_t ma, input fcw_mode_t mb);
		chk("bank a mode", {6'h00, ma}, {6'h00, bank_a_stat.mode});
		chk("bank b mode", {6'h00, mb}, {6'h00, bank_b_stat.mode});
	endtask : modes

	task automatic done(input logic to_a);
		@(posedge clk);
		op_done_a <= to_a;
		op_done_b <= !to_a;
		@(posedge clk);
		op_done_a <= 1'b0;
		op_done_b <= 1'b0;
	endtask : done

	// Hang guard: a run this long counts as a mismatch
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		stop_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst <= 1'b1;
		op_done_a <= 1'b0;
		op_done_b <= 1'b0;
		rows = '{
			'{22'h000555, CMD_WAIT, FCW_MODE_READ, FCW_MODE_READ, 3'h4},
			'{22'h301555, CMD_WAIT, FCW_MODE_READ, FCW_MODE_READ, 3'h5},
			'{22'h002555, CMD_WAIT, FCW_MODE_READ, FCW_MODE_READ, 3'h6},
			'{22'h303555, CMD_WAIT, FCW_MODE_READ, FCW_MODE_READ, 3'h7},
			'{22'h2FF555, CMD_ASEL, FCW_MODE_READ, FCW_MODE_ASEL, 3'h7},
			'{22'h300555, CMD_ASEL, FCW_MODE_ASEL, FCW_MODE_READ, 3'h7},
			'{22'h000555, 8'h12, FCW_MODE_READ, FCW_MODE_READ, 3'h7},
			'{22'h000556, CMD_WAIT, FCW_MODE_READ, FCW_MODE_READ, 3'h7}
		};
		settle(3);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		chk("wait", 8'h07, {5'h00, wait_cycles});
		@(posedge clk);
		rst <= 1'b0;
		// Table rows: wait codes, bank boundary, bad data and address
		for (int i = 0; i < 8; i++) begin
			fcw_host_model_i.cmd3(rows[i].a, rows[i].d);
			settle(8);
			modes(rows[i].ma, rows[i].mb);
			chk("wait", {5'h00, rows[i].w}, {5'h00, wait_cycles});
			fcw_host_model_i.reset_cmd(22'h000000);
			fcw_host_model_i.reset_cmd(22'h300000);
		end
		// Bad second unlock cycle aborts, so the later C0h is not a command
		fcw_host_model_i.wr(22'h000555, {8'h00, CMD_UNLK1});
		fcw_host_model_i.wr(22'h000555, {8'h00, CMD_UNLK2});
		fcw_host_model_i.wr(22'h001555, {8'h00, CMD_WAIT});
		settle(8);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		chk("wait", 8'h07, {5'h00, wait_cycles});
		// Wait command in bank A leaves autoselect of bank B alone
		fcw_host_model_i.cmd3(22'h000555, CMD_ASEL);
		fcw_host_model_i.cmd3(22'h300555, CMD_WAIT);
		fcw_host_model_i.wr(22'h000003, 16'h0055);
		settle(8);
		modes(FCW_MODE_READ, FCW_MODE_ASEL);
		fcw_host_model_i.reset_cmd(22'h000000);
		settle(8);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		// Program in B; reset ignored until the algorithm finishes
		fcw_host_model_i.cmd3(22'h000555, CMD_PGM);
		fcw_host_model_i.wr(22'h000100, 16'h1234);
		fcw_host_model_i.reset_cmd(22'h000000);
		settle(4);
		modes(FCW_MODE_READ, FCW_MODE_BUSY);
		chk("op erase", 8'h00, {7'h00, bank_b_stat.op_erase});
		done(1'b0);
		settle(4);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		// Erase in A, suspend, program inside suspend, autoselect, resume
		fcw_host_model_i.cmd3(22'h300555, CMD_ERASE);
		fcw_host_model_i.cmd3(22'h340000, CMD_SECT_ERS);
		settle(8);
		modes(FCW_MODE_BUSY, FCW_MODE_READ);
		chk("op erase", 8'h01, {7'h00, bank_a_stat.op_erase});
		fcw_host_model_i.wr(22'h300000, {8'h00, CMD_SUSPEND});
		settle(8);
		modes(FCW_MODE_ESR, FCW_MODE_READ);
		fcw_host_model_i.cmd3(22'h300555, CMD_PGM);
		fcw_host_model_i.wr(22'h3F8000, 16'h00A5);
		settle(8);
		modes(FCW_MODE_BUSY, FCW_MODE_READ);
		done(1'b1);
		settle(4);
		modes(FCW_MODE_ESR, FCW_MODE_READ);
		fcw_host_model_i.cmd3(22'h300555, CMD_ASEL);
		fcw_host_model_i.reset_cmd(22'h300000);
		settle(8);
		modes(FCW_MODE_ESR, FCW_MODE_READ);
		fcw_host_model_i.wr(22'h300000, {8'h00, CMD_RESUME});
		settle(2);
		modes(FCW_MODE_BUSY, FCW_MODE_READ);
		done(1'b1);
		settle(4);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		// Burst initial access with five cycles, then a new address strobe
		fcw_host_model_i.cmd3(22'h001555, CMD_WAIT);
		fcw_host_model_i.strobe(22'h100000);
		fcw_host_model_i.rises(4);
		settle(1);
		chk("ready", 8'h00, {7'h00, first_access_ready});
		fcw_host_model_i.rises(1);
		settle(1);
		chk("ready", 8'h01, {7'h00, first_access_ready});
		fcw_host_model_i.strobe(22'h100008);
		settle(1);
		chk("ready", 8'h00, {7'h00, first_access_ready});
		chk("op starts", 8'h03, start_count);
		chk("wait cmds", 8'h06, ws_count);
		// Hardware reset brings back the default setting and read mode
		fcw_host_model_i.cmd3(22'h000555, CMD_ASEL);
		settle(8);
		modes(FCW_MODE_READ, FCW_MODE_ASEL);
		@(posedge clk);
		rst <= 1'b1;
		settle(4);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		chk("wait", 8'h07, {5'h00, wait_cycles});
		@(posedge clk);
		rst <= 1'b0;
		settle(2);
		modes(FCW_MODE_READ, FCW_MODE_READ);
		chk("ready", 8'h00, {7'h00, first_access_ready});
		stop_test();
	end
endmodule : flash_command_waitstate_decode_tb
